// ===== oss_master.sv
// Serial master model that frames command words and gathers status.
`timescale 1ns/1ps
module oss_master (
	// Clock and link.
	input  wire logic                  clock,
	input  wire logic                  sdo,
	output      oss_pkg::oss_link_in_t link
);
	import oss_pkg::*;
	// Idle clock rests low and idle data at its pulled-up level.
	initial link = '{sclk: 1'b0, sel_n: 1'b1, sdi: 1'b1};
	task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
		r = 16'h0000;
		link.sel_n <= 1'b0;
		repeat (4) @(posedge clock);
		for (int i = n - 1; i >= 0; i--) begin
			link.sdi  <= w[i];
			link.sclk <= 1'b1;
			repeat (4) @(posedge clock);
			r = {r[14:0], sdo};
			link.sclk <= 1'b0;
			repeat (4) @(posedge clock);
		end
		link.sel_n <= 1'b1;
		link.sdi   <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
	// Toggles clock and data while deselected, only when a test asks.
	task automatic noise(input logic [15:0] v);
		for (int i = 0; i < 16; i++) begin
			link.sclk <= v[i];
			link.sdi  <= ~v[i];
			@(posedge clock);
		end
		link.sclk <= 1'b0;
	endtask
endmodule

// ===== oss_pkg.sv
// Package with constants and types for the octal switch serial control block.
package oss_pkg;
	localparam int NUM_OUT = 8;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [1:0] SYNC_RESET = 2'h0;
	localparam logic [1:0] SYNC_IDLE_HIGH = 2'h3;

	typedef struct packed {
		logic sclk;
		logic sel_n;
		logic sdi;
	} oss_link_in_t;

	typedef struct packed {
		logic sdo;
		logic sdo_oe_n;
	} oss_link_out_t;

	typedef enum logic [1:0] {
		OSS_IDLE,
		OSS_ACTIVE
	} oss_state_t;
endpackage

// ===== oss_top.sv
// Serial control port, command latch and per-output fault latches.
`timescale 1ns/1ps
module oss_top (
	// Clock and reset.
	input  wire logic                      clock,
	input  wire logic                      rst,
	// Serial link pins.
	input  wire oss_pkg::oss_link_in_t     link_in,
	output      oss_pkg::oss_link_out_t    link_out,
	// Output stage interface.
	input  wire logic [7:0]                drain_level,
	input  wire logic [7:0]                short_detect,
	input  wire logic                      short_latch_disable,
	output      logic [7:0]                out_on
);
	import oss_pkg::*;

	// Two-flop synchronisers; only the second stage is read.
	logic [1:0] sclk_s_reg, sclk_s_next;
	logic [1:0] sel_s_reg, sel_s_next;
	logic [1:0] sdi_s_reg, sdi_s_next;
	logic [1:0] sfd_s_reg, sfd_s_next;
	// Output stage levels come from another domain, so they are synchronised too.
	logic [7:0] drain_m_reg, drain_m_next;
	logic [7:0] drain_s_reg, drain_s_next;
	logic [7:0] short_m_reg, short_m_next;
	logic [7:0] short_s_reg, short_s_next;
	logic       sclk_d_reg, sclk_d_next;
	logic       sel_d_reg, sel_d_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [7:0] fault_reg, fault_next;
	logic       sdo_reg, sdo_next;
	logic [7:0] out_on_reg, out_on_next;
	oss_state_t state_reg, state_next;

	logic sclk_rise, sclk_fall, sel_rise, sel_fall;

	assign sclk_rise = sclk_s_reg[1] & ~sclk_d_reg;
	assign sclk_fall = ~sclk_s_reg[1] & sclk_d_reg;
	assign sel_rise  = sel_s_reg[1] & ~sel_d_reg;
	assign sel_fall  = ~sel_s_reg[1] & sel_d_reg;

	always_comb begin
		sclk_s_next = {sclk_s_reg[0], link_in.sclk};
		sel_s_next  = {sel_s_reg[0], link_in.sel_n};
		sdi_s_next  = {sdi_s_reg[0], link_in.sdi};
		sfd_s_next  = {sfd_s_reg[0], short_latch_disable};
		drain_m_next = drain_level;
		drain_s_next = drain_m_reg;
		short_m_next = short_detect;
		short_s_next = short_m_reg;
		sclk_d_next = sclk_s_reg[1];
		sel_d_next  = sel_s_reg[1];
		shift_next  = shift_reg;
		cmd_next    = cmd_reg;
		sdo_next    = sdo_reg;
		state_next  = state_reg;
		case (state_reg)
			OSS_IDLE: begin
				if (sel_fall) begin
					// Snapshot drain levels, so a fault-dropped output shows its real drain.
					shift_next = drain_s_reg;
					sdo_next   = drain_s_reg[NUM_OUT-1];
					state_next = OSS_ACTIVE;
				end
			end
			OSS_ACTIVE: begin
				if (sel_rise) begin
					cmd_next   = shift_reg;
					state_next = OSS_IDLE;
				end else if (sclk_rise) begin
					sdo_next = shift_reg[NUM_OUT-1];
				end else if (sclk_fall) begin
					shift_next = {shift_reg[NUM_OUT-2:0], sdi_s_reg[1]};
				end
			end
			default: state_next = OSS_IDLE;
		endcase
	end

	// Each output owns a fault latch, cleared when a new command is latched.
	// A short in the same cycle as the latch wins over the clear.
	always_comb begin
		fault_next = fault_reg;
		for (int i = 0; i < NUM_OUT; i++) begin
			if (short_s_reg[i] && !sfd_s_reg[1] && !cmd_reg[i]) begin
				fault_next[i] = 1'b1;
			end else if (sel_rise) begin
				fault_next[i] = 1'b0;
			end
		end
		out_on_next = ~cmd_next & ~fault_next;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_s_reg <= SYNC_RESET;
			sel_s_reg  <= SYNC_IDLE_HIGH;
			sdi_s_reg  <= SYNC_RESET;
			sfd_s_reg  <= SYNC_RESET;
			drain_m_reg <= CMD_RESET;
			drain_s_reg <= CMD_RESET;
			short_m_reg <= SHIFT_RESET;
			short_s_reg <= SHIFT_RESET;
			sclk_d_reg <= 1'b0;
			sel_d_reg  <= 1'b1;
			shift_reg  <= SHIFT_RESET;
			cmd_reg    <= CMD_RESET;
			fault_reg  <= SHIFT_RESET;
			out_on_reg <= ~CMD_RESET;
			state_reg  <= OSS_IDLE;
		end else begin
			sclk_s_reg <= sclk_s_next;
			sel_s_reg  <= sel_s_next;
			sdi_s_reg  <= sdi_s_next;
			sfd_s_reg  <= sfd_s_next;
			drain_m_reg <= drain_m_next;
			drain_s_reg <= drain_s_next;
			short_m_reg <= short_m_next;
			short_s_reg <= short_s_next;
			sclk_d_reg <= sclk_d_next;
			sel_d_reg  <= sel_d_next;
			shift_reg  <= shift_next;
			cmd_reg    <= cmd_next;
			fault_reg  <= fault_next;
			out_on_reg <= out_on_next;
			state_reg  <= state_next;
		end
	end

	// The serial data flop is left out of reset, since reset must not disturb it.
	always_ff @(posedge clock) begin
		sdo_reg <= sdo_next;
	end

	assign out_on   = out_on_reg;
	assign link_out = '{sdo: sdo_reg, sdo_oe_n: sel_s_reg[1]};

	// Frame steps as the core sees them, after synchronisation.
	sequence seq_frame_open;
		state_reg == OSS_IDLE && sel_fall;
	endsequence

	sequence seq_frame_close;
		state_reg == OSS_ACTIVE && sel_rise;
	endsequence

	sequence seq_bit_out;
		state_reg == OSS_ACTIVE && sclk_rise && !sel_rise;
	endsequence

	sequence seq_bit_in;
		state_reg == OSS_ACTIVE && sclk_fall && !sel_rise;
	endsequence

	// Properties below, except the two reset checks, skip reset, since reset may land in the middle of a frame.
	AST_RESET_OFF: assert property (@(posedge clock)
		rst
		|=> out_on == 8'h00)
		else $error("Outputs not off after reset.");

	AST_RESET_SHIFT: assert property (@(posedge clock)
		rst
		|=> shift_reg == SHIFT_RESET)
		else $error("Shift register not cleared by reset.");

	AST_LATCH: assert property (@(posedge clock) disable iff (rst)
		seq_frame_close
		|=> cmd_reg == $past(shift_reg))
		else $error("Command not latched on select rise.");

	AST_STATE_CLOSE: assert property (@(posedge clock) disable iff (rst)
		seq_frame_close
		|=> state_reg == OSS_IDLE)
		else $error("Frame not closed on select rise.");

	AST_STATE_OPEN: assert property (@(posedge clock) disable iff (rst)
		seq_frame_open
		|=> state_reg == OSS_ACTIVE)
		else $error("Frame not opened on select fall.");

	AST_LOAD: assert property (@(posedge clock) disable iff (rst)
		seq_frame_open
		|=> shift_reg == $past(drain_s_reg))
		else $error("Status not loaded on select fall.");

	AST_SDO_FIRST: assert property (@(posedge clock) disable iff (rst)
		seq_frame_open
		|=> sdo_reg == $past(drain_s_reg[NUM_OUT-1]))
		else $error("First status bit not on serial output.");

	AST_SHIFT: assert property (@(posedge clock) disable iff (rst)
		seq_bit_in
		|=> shift_reg == {$past(shift_reg[NUM_OUT-2:0]), $past(sdi_s_reg[1])})
		else $error("Input bit not shifted in.");

	AST_SDO_MSB: assert property (@(posedge clock) disable iff (rst)
		seq_bit_out
		|=> sdo_reg == $past(shift_reg[NUM_OUT-1]))
		else $error("Serial output not MSB.");

	AST_HOLD: assert property (@(posedge clock) disable iff (rst)
		(state_reg == OSS_IDLE && !sel_fall)
		|=> $stable(shift_reg))
		else $error("Shift register moved while deselected.");

	AST_CMD_HOLD: assert property (@(posedge clock) disable iff (rst)
		!(state_reg == OSS_ACTIVE && sel_rise)
		|=> $stable(cmd_reg))
		else $error("Command changed outside a select rise.");

	AST_IDLE_RELEASE: assert property (@(posedge clock) disable iff (rst)
		(state_reg == OSS_IDLE && !sel_fall)
		|-> link_out.sdo_oe_n)
		else $error("Serial output driven while deselected.");

	AST_POLARITY: assert property (@(posedge clock) disable iff (rst)
		seq_frame_close
		|=> out_on == (~$past(shift_reg) & ~fault_reg))
		else $error("Inverted polarity broken.");

	AST_FAULT: assert property (@(posedge clock) disable iff (rst)
		((short_s_reg & ~cmd_reg) != 8'h00 && !sfd_s_reg[1])
		|=> (out_on & $past(short_s_reg & ~cmd_reg)) == 8'h00)
		else $error("Faulted output not shut down.");

	AST_FAULT_LOCAL: assert property (@(posedge clock) disable iff (rst)
		(fault_reg & ~$past(fault_reg)
		& ~$past(short_s_reg)) == 8'h00)
		else $error("Fault latched on an output without a short.");
endmodule

// ===== oss_top_tb.sv
// Self-checking bench for the serial control block.
`timescale 1ns/1ps
module oss_top_tb;
	import oss_pkg::*;
	logic          clock = 1'b0;
	logic          rst = 1'b1;
	logic [7:0]    drain = 8'hFF;
	logic [7:0]    short = 8'h00;
	logic          sld = 1'b0;
	oss_link_in_t  link_in;
	oss_link_out_t link_out;
	logic [7:0]    out_on;
	logic [15:0]   rd;
	logic [15:0]   w;
	logic [31:0]   seed = 32'h12;
	logic          q[$];
	logic [15:0]   exp_rd;
	logic [7:0]    exp_on;
	int            bad_count = 0;
	int            compares = 0;
	always #20 clock = ~clock;
	oss_top DUT (.clock(clock), .rst(rst), .link_in(link_in), .link_out(link_out),
		.drain_level(drain), .short_detect(short), .short_latch_disable(sld), .out_on(out_on));
	oss_master PM (.clock(clock), .sdo(link_out.sdo), .link(link_in));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Reference chain: status bits first, every command bit pushed in behind them.
	task automatic model(input int n, input logic [15:0] cw, input logic [7:0] st);
		q = {};
		exp_rd = 16'h0000;
		for (int i = 7; i >= 0; i--) q.push_back(st[i]);
		for (int i = n - 1; i >= 0; i--) begin
			exp_rd = {exp_rd[14:0], q.pop_front()};
			q.push_back(cw[i]);
		end
		for (int i = 0; i < 8; i++) exp_on[7 - i] = ~q[i];
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clock);
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk(out_on, 8'h00);
		chk(link_out.sdo_oe_n, 1'b1);
		for (int k = 0; k < 8; k++) begin
			w = {8'h00, rnd()};
			drain <= rnd();
			@(posedge clock);
			PM.xfer(8, w, rd);
			model(8, w, drain);
			chk(rd, exp_rd);
			chk(out_on, exp_on);
		end
		w = {rnd(), rnd()};
		PM.xfer(16, w, rd);
		model(16, w, drain);
		chk(rd, exp_rd);
		chk(out_on, exp_on);
		w = 16'h0000;
		PM.xfer(8, w, rd);
		model(8, w, drain);
		chk(rd, exp_rd);
		chk(out_on, exp_on);
		short <= 8'h04;
		repeat (6) @(posedge clock);
		short <= 8'h00;
		sld <= 1'b1;
		repeat (4) @(posedge clock);
		chk(out_on, 8'hFB);
		short <= 8'h10;
		drain <= 8'h04;
		repeat (6) @(posedge clock);
		short <= 8'h00;
		repeat (4) @(posedge clock);
		chk(out_on, 8'hFB);
		PM.xfer(8, w, rd);
		chk(rd, 16'h0004);
		chk(out_on, 8'hFF);
		PM.noise({rnd(), rnd()});
		repeat (6) @(posedge clock);
		chk(out_on, 8'hFF);
		chk(link_out.sdo_oe_n, 1'b1);
		rst <= 1'b1;
		@(posedge clock);
		chk(out_on, 8'h00);
		rst <= 1'b0;
		@(posedge clock);
		PM.xfer(8, w, rd);
		model(8, w, drain);
		chk(rd, exp_rd);
		chk(out_on, exp_on);
		wrap_up();
	end
endmodule
